// [logic/vfd_led_auto_display_scan.sv]
// Automatic fluorescent tube and LED display scanner with Wishbone registers.
//
// Functional notes
// - Display memory holds 32 slots of 60 bits each.
// - Slots per scan configurable from 1 to 32.
// - Up to 32 digit pins, 60 digit and segment pins in total.
// - Digits are consecutive pins from start pin, count set by register.
// - At most 60 segment outputs are controlled, 59 with one digit.
// - Four selectable slot widths.
// - Digit dimming, seven steps, one setting for all digits.
// - Option inverts every digit and segment output.
// - Segment dimming on any chosen slot.
// - LED segments show slot 1 while common high, slot 2 while low.
// - LED common phase 5.12 ms, segment phase 4.096 ms at 16 MHz.
// - Start register is write-only, byte writes, no read-modify-write.
// - Start register bits 7 to 2 unused; writes ignored.
// - Bit 1 starts LED display when 1, stops when 0.
// - LED start drives common high with slot 1 data.
// - LED stop turns all LED outputs off immediately.
// - Bit 0 starts tube display when 1, stops when 0.
// - Tube display starts with slot 1 contents.
// - Tube stop finishes current slot, then switches outputs off.
// - Width codes give 2^11, 2^12, 2^13, 2^14 clocks per slot.
// - Slot count value v scans slots 1 through v+1.
// - Inversion affects tube outputs only, never LED outputs.
//
// The Wishbone register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module vfd_led_auto_display_scan #(
    parameter int SLOT_SHIFT_BASE = vfd_scan_pkg::SLOT_SHIFT_MIN,
    parameter int LED_COM_LEN     = vfd_scan_pkg::LED_COM_CYCLES,
    parameter int LED_SEG_LEN     = vfd_scan_pkg::LED_SEG_CYCLES
) (
    input  wire logic                                clk_i,
    input  wire logic                                rst_i,
    input  wire logic                                cyc_i,
    input  wire logic                                stb_i,
    input  wire logic                                we_i,
    input  wire logic [9:0]                          adr_i,
    input  wire logic [3:0]                          sel_i,
    input  wire logic [31:0]                         dat_i,
    output logic      [31:0]                         dat_o,
    output logic                                     ack_o,
    output logic      [vfd_scan_pkg::HV_PINS-1:0]    high_voltage_outputs_o,
    output logic                                     led_common_output_o,
    output logic      [vfd_scan_pkg::LED_SEGS-1:0]   led_segment_outputs_o
);
    import vfd_scan_pkg::*;

    localparam int PH_W  = SLOT_SHIFT_BASE + 3;
    localparam int LED_W = $clog2(LED_COM_LEN + 1);

    // ****************************************************************
    // Bus slave
    // ****************************************************************
    logic              ack_q;
    logic [31:0]       dat_q;
    logic              req;
    logic              wr;
    logic              ctrl_wr;
    logic              mem_hit;
    logic [4:0]        mem_slot;
    logic              mem_hi;

    assign req      = cyc_i && stb_i && !ack_q;
    assign wr       = req && we_i;
    // Control writes need the low lane enabled; the digit dim field and the
    // upper segment mask bytes are taken from the higher lanes.
    assign ctrl_wr  = wr && sel_i[0];
    assign mem_hit  = adr_i >= ADDR_MEM_BASE && adr_i <= ADDR_MEM_END;
    assign mem_slot = adr_i[MEM_SLOT_LSB +: 5];
    assign mem_hi   = adr_i[MEM_WORD_BIT];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    logic              tube_en_q;
    logic              led_en_q;
    logic              invert_q;
    logic [1:0]        width_q;
    logic [4:0]        last_slot_q;
    logic [4:0]        digit_start_q;
    logic [2:0]        digit_dim_q;
    logic [5:0]        digit_count_q;
    logic [SLOTS-1:0]  seg_mask_q;
    logic [2:0]        seg_dim_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tube_en_q     <= 1'b0;
            led_en_q      <= 1'b0;
            invert_q      <= CONFIG_RESET[INVERT_BIT];
            width_q       <= CONFIG_RESET[WIDTH_LSB +: 2];
            last_slot_q   <= CONFIG_RESET[COUNT_LSB +: 5];
            digit_start_q <= DIGIT_START_RESET;
            digit_dim_q   <= DIM_OFF;
            digit_count_q <= DIGIT_COUNT_RESET;
            seg_mask_q    <= '0;
            seg_dim_q     <= DIM_OFF;
        end else if (ctrl_wr) begin
            unique case (adr_i)
                ADDR_START_CTRL: begin
                    tube_en_q <= dat_i[TUBE_START_BIT];
                    led_en_q  <= dat_i[LED_START_BIT];
                end
                ADDR_CONFIG_CTRL: begin
                    invert_q    <= dat_i[INVERT_BIT];
                    width_q     <= dat_i[WIDTH_LSB +: 2];
                    last_slot_q <= dat_i[COUNT_LSB +: 5];
                end
                ADDR_DIGIT_START: begin
                    digit_start_q <= dat_i[4:0];
                    digit_dim_q   <= dat_i[DIM_LSB +: 3];
                end
                ADDR_DIGIT_COUNT: begin
                    digit_count_q <= dat_i[5:0];
                end
                ADDR_SEG_MASK: begin
                    for (int b = 0; b < 4; b++) begin
                        if (sel_i[b]) begin
                            seg_mask_q[8*b +: 8] <= dat_i[8*b +: 8];
                        end
                    end
                end
                ADDR_SEG_LEVEL: begin
                    seg_dim_q <= dat_i[2:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // Display memory
    // ****************************************************************
    // memory of 32 by 60 bits.
    logic [HV_PINS-1:0] mem_q [SLOTS];

    always_ff @(posedge clk_i) begin
        if (wr && mem_hit) begin
            for (int b = 0; b < 4; b++) begin
                if (sel_i[b]) begin
                    if (mem_hi) begin
                        if (32 + 8*b < HV_PINS) begin
                            mem_q[mem_slot][32 + 8*b +: 4] <= dat_i[8*b +: 4];
                        end
                        if (36 + 8*b < HV_PINS) begin
                            mem_q[mem_slot][36 + 8*b +: 4] <= dat_i[8*b + 4 +: 4];
                        end
                    end else begin
                        mem_q[mem_slot][8*b +: 8] <= dat_i[8*b +: 8];
                    end
                end
            end
        end
    end

    // ****************************************************************
    // Tube scan
    // ****************************************************************
    logic              tube_run_q;
    logic [4:0]        slot_q;
    logic [PH_W-1:0]   phase_q;
    logic [PH_W-1:0]   phase_last;
    logic              tick;
    logic              tube_go;
    logic [2:0]        frac;

    assign phase_last = PH_W'((1 << (SLOT_SHIFT_BASE + int'(width_q))) - 1);
    assign tick       = phase_q == phase_last;
    assign tube_go    = ctrl_wr && adr_i == ADDR_START_CTRL && dat_i[TUBE_START_BIT]
                        && !tube_run_q;
    assign frac       = 3'(phase_q >> (SLOT_SHIFT_BASE - 3 + int'(width_q)));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tube_run_q <= 1'b0;
            slot_q     <= '0;
            phase_q    <= '0;
        end else if (tube_go) begin
            tube_run_q <= 1'b1;
            slot_q     <= '0;
            phase_q    <= '0;
        end else if (tube_run_q) begin
            if (tick) begin
                phase_q <= '0;
                tube_run_q <= tube_en_q;
                slot_q <= (slot_q == last_slot_q) ? 5'h00 : slot_q + 5'h01;
            end else begin
                phase_q <= phase_q + PH_W'(1);
            end
        end
    end

    // Dimming passes the first (8 - level) eighths of each slot, so
    // level 0 is full brightness and levels 1 to 7 are the seven steps.
    logic               digit_on;
    logic               seg_on;
    logic [HV_PINS-1:0] fip_d;
    logic [HV_PINS-1:0] fip_q;

    // one digit dimmer for all digits.
    assign digit_on = {1'b0, frac} < (4'h8 - {1'b0, digit_dim_q});
    assign seg_on   = !seg_mask_q[slot_q] ||
                      ({1'b0, frac} < (4'h8 - {1'b0, seg_dim_q}));

    always_comb begin
        for (int p = 0; p < HV_PINS; p++) begin
            // digits are consecutive among first 32.
            // any other pin is a segment, at most 59 with one digit.
            if (p < DIGIT_PINS && p >= int'(digit_start_q) &&
                p < int'(digit_start_q) + int'(digit_count_q)) begin
                fip_d[p] = tube_run_q && mem_q[slot_q][p] && digit_on;
            end else begin
                fip_d[p] = tube_run_q && mem_q[slot_q][p] && seg_on;
            end
        end
        fip_d = fip_d ^ {HV_PINS{invert_q}};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fip_q <= '0;
        end else begin
            fip_q <= fip_d;
        end
    end

    // ****************************************************************
    // LED scan
    // ****************************************************************
    logic               led_run_q;
    logic               com_q;
    logic [LED_W-1:0]   led_cnt_q;
    logic               led_go;
    logic               led_stop;
    logic               led_com_q;
    logic [LED_SEGS-1:0] led_seg_q;

    assign led_go   = ctrl_wr && adr_i == ADDR_START_CTRL && dat_i[LED_START_BIT];
    assign led_stop = ctrl_wr && adr_i == ADDR_START_CTRL && !dat_i[LED_START_BIT];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            led_run_q <= 1'b0;
            com_q     <= 1'b0;
            led_cnt_q <= '0;
        end else if (led_stop) begin
            led_run_q <= 1'b0;
            com_q     <= 1'b0;
            led_cnt_q <= '0;
        end else if (led_go && !led_run_q) begin
            led_run_q <= 1'b1;
            com_q     <= 1'b1;
            led_cnt_q <= '0;
        end else if (led_run_q) begin
            if (led_cnt_q == LED_W'(LED_COM_LEN - 1)) begin
                led_cnt_q <= '0;
                com_q     <= !com_q;
            end else begin
                led_cnt_q <= led_cnt_q + LED_W'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            led_com_q <= 1'b0;
            led_seg_q <= '0;
        end else if (!led_run_q || led_stop) begin
            led_com_q <= 1'b0;
            led_seg_q <= '0;
        end else begin
            led_com_q <= com_q;
            if (led_cnt_q < LED_W'(LED_SEG_LEN)) begin
                led_seg_q <= com_q ? mem_q[0][LED_SEGS-1:0] : mem_q[1][LED_SEGS-1:0];
            end else begin
                led_seg_q <= '0;
            end
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= '0;
        end else if (req && !we_i) begin
            dat_q <= '0;
            if (mem_hit) begin
                dat_q <= mem_hi ? 32'(mem_q[mem_slot][HV_PINS-1:32])
                                : mem_q[mem_slot][31:0];
            end else if (adr_i == ADDR_STATUS) begin
                dat_q[STAT_TUBE_BIT]         <= tube_run_q;
                dat_q[STAT_LED_BIT]          <= led_run_q;
                dat_q[STAT_COM_BIT]          <= com_q;
                dat_q[STAT_SLOT_LSB +: 5]    <= slot_q;
            end else if (adr_i == ADDR_SEG_MASK) begin
                dat_q <= seg_mask_q;
            end
        end
    end

    assign dat_o                  = dat_q;
    assign ack_o                  = ack_q;
    assign high_voltage_outputs_o = fip_q;
    assign led_common_output_o    = led_com_q;
    assign led_segment_outputs_o  = led_seg_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence led_stop_req_s;
        led_stop;
    endsequence

    sequence led_dark_s;
        !led_run_q ##1 (!led_com_q && led_seg_q == '0);
    endsequence

    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_q |=> !ack_q) else $error("ack held longer than one cycle");

    a_led_stop_dark: assert property (@(posedge clk_i) disable iff (rst_i)
        led_stop_req_s |=> led_dark_s) else $error("LED outputs not blanked on stop");

    a_led_start_com: assert property (@(posedge clk_i) disable iff (rst_i)
        led_go && !led_run_q |=> com_q ##1 led_com_q) else $error("LED start not common high");

    a_tube_start_slot: assert property (@(posedge clk_i) disable iff (rst_i)
        tube_go |=> tube_run_q && slot_q == 5'h00 && phase_q == '0)
        else $error("tube scan did not start at first slot");

    a_slot_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
        tube_run_q && tick && slot_q == last_slot_q && !tube_go |=> slot_q == 5'h00)
        else $error("slot did not wrap after last");

    a_slot_step: assert property (@(posedge clk_i) disable iff (rst_i)
        tube_run_q && tick && slot_q != last_slot_q && !tube_go
        |=> slot_q == $past(slot_q) + 5'h01) else $error("slot did not advance");

    a_tube_stop_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        tube_run_q && !tick |=> tube_run_q) else $error("tube stopped inside a slot");

    a_tube_idle_level: assert property (@(posedge clk_i) disable iff (rst_i)
        !tube_run_q ##1 !tube_run_q |-> fip_q == {HV_PINS{$past(invert_q)}})
        else $error("idle tube outputs not at inactive level");

    a_led_com_phase: assert property (@(posedge clk_i) disable iff (rst_i)
        led_run_q && !led_stop && led_cnt_q != LED_W'(LED_COM_LEN - 1) |=> $stable(com_q))
        else $error("LED common toggled early");

endmodule

// [logic/vfd_scan_pkg.sv]
// Constants shared by the fluorescent and LED display scanner.
package vfd_scan_pkg;

    // ****************************************************************
    // Register map (byte addresses on the 32-bit bus)
    // ****************************************************************
    localparam logic [9:0] ADDR_START_CTRL  = 10'h000;
    localparam logic [9:0] ADDR_CONFIG_CTRL = 10'h004;
    localparam logic [9:0] ADDR_DIGIT_START = 10'h008;
    localparam logic [9:0] ADDR_DIGIT_COUNT = 10'h00C;
    localparam logic [9:0] ADDR_SEG_MASK    = 10'h010;
    localparam logic [9:0] ADDR_SEG_LEVEL   = 10'h014;
    localparam logic [9:0] ADDR_STATUS      = 10'h018;
    localparam logic [9:0] ADDR_MEM_BASE    = 10'h100;
    localparam logic [9:0] ADDR_MEM_END     = 10'h1FC;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int TUBE_START_BIT = 0;
    localparam int LED_START_BIT  = 1;
    localparam int INVERT_BIT     = 7;
    localparam int WIDTH_LSB      = 5;
    localparam int COUNT_LSB      = 0;
    localparam int DIM_LSB        = 8;
    localparam int STAT_TUBE_BIT  = 0;
    localparam int STAT_LED_BIT   = 1;
    localparam int STAT_COM_BIT   = 2;
    localparam int STAT_SLOT_LSB  = 8;
    localparam int MEM_WORD_BIT   = 2;
    localparam int MEM_SLOT_LSB   = 3;

    // ****************************************************************
    // Sizes, reset values and timing
    // ****************************************************************
    localparam int SLOTS       = 32;
    localparam int HV_PINS     = 60;
    localparam int DIGIT_PINS  = 32;
    localparam int LED_SEGS    = 16;
    localparam int SLOT_SHIFT_MIN = 11;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [4:0] DIGIT_START_RESET = 5'h00;
    localparam logic [5:0] DIGIT_COUNT_RESET = 6'h00;
    localparam logic [2:0] DIM_OFF = 3'h0;
    localparam logic [2:0] DIM_FULL = 3'h7;
    localparam int REF_CLK_MHZ     = 16;
    localparam int LED_COM_TIME_NS = 5_120_000;
    localparam int LED_SEG_TIME_NS = 4_096_000;
    localparam int LED_COM_CYCLES  = LED_COM_TIME_NS / 1000 * REF_CLK_MHZ;
    localparam int LED_SEG_CYCLES  = LED_SEG_TIME_NS / 1000 * REF_CLK_MHZ;

endpackage

// [tb/display_panel_model.sv]
// Passive model of the LED panel on the scanner's LED common pin.
`timescale 1ns/10ps
module display_panel_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        common_i,
    output logic      [15:0] com_rises_o
);
    logic common_q;

    // A common rise marks one half-duty LED frame; the panel has no other memory.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            common_q    <= 1'b0;
            com_rises_o <= 16'h0000;
        end else begin
            common_q <= common_i;
            if (common_i && !common_q) begin
                com_rises_o <= com_rises_o + 16'h0001;
            end
        end
    end
endmodule

// [tb/vfd_led_auto_display_scan_test.sv]
// Self-checking bench for the automatic display scanner.
`timescale 1ns/10ps
module vfd_led_auto_display_scan_test;
    import vfd_scan_pkg::*;
    localparam int BASE    = 3;
    localparam int COM_LEN = 40;
    localparam int SEG_LEN = 32;
    logic                clk_i = 1'b0;
    logic                rst_i = 1'b1;
    logic                cyc_i = 1'b0;
    logic                stb_i = 1'b0;
    logic                we_i  = 1'b0;
    logic [9:0]          adr_i = 10'h000;
    logic [3:0]          sel_i = 4'h0;
    logic [31:0]         dat_i = 32'h0000_0000;
    logic [31:0]         dat_o;
    logic                ack_o;
    logic [HV_PINS-1:0]  pins;
    logic                common;
    logic [LED_SEGS-1:0] segs;
    logic [15:0]         com_rises;
    logic [31:0]         seed = 32'hc073_2658;
    logic [59:0]         mem [4];
    logic [31:0]         rd;
    int                  errors = 0;
    int                  checks_done = 0;

    always #20 clk_i = ~clk_i;

    vfd_led_auto_display_scan #(
        .SLOT_SHIFT_BASE(BASE),
        .LED_COM_LEN    (COM_LEN),
        .LED_SEG_LEN    (SEG_LEN)
    ) DUT (
        .clk_i                 (clk_i),
        .rst_i                 (rst_i),
        .cyc_i                 (cyc_i),
        .stb_i                 (stb_i),
        .we_i                  (we_i),
        .adr_i                 (adr_i),
        .sel_i                 (sel_i),
        .dat_i                 (dat_i),
        .dat_o                 (dat_o),
        .ack_o                 (ack_o),
        .high_voltage_outputs_o(pins),
        .led_common_output_o   (common),
        .led_segment_outputs_o (segs)
    );

    display_panel_model panel (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .common_i   (common),
        .com_rises_o(com_rises)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [59:0] exp_pins(input logic [59:0] m, input logic inv);
        return m ^ {60{inv}};
    endfunction

    // Scan step j is slot (j / 8) % 2 at phase j % 8; digits at level 4, slot 0 segments at level 2.
    function automatic logic [59:0] exp_dim(input logic [59:0] m, input int j);
        logic [59:0] dig;
        logic        d_on;
        logic        s_on;
        dig  = 60'h000_0000_0000_0ff0;
        d_on = (j % 8) < 8 - 4;
        s_on = ((j / 8) % 2 != 0) || ((j % 8) < 8 - 2);
        return (m & dig & {60{d_on}}) | (m & ~dig & {60{s_on}});
    endfunction

    task automatic chk_pins(input string name, input logic [59:0] e, input logic [59:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic chk_word(input string name, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask

    // One classic cycle; the request stands until ack is sampled high.
    task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hf;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        rd = dat_o;
        if (n >= 50) begin
            errors++;
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    // Lets edges pass, then steps off the edge so registered outputs have settled.
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic results();
        if (errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        int   dur;
        logic inv;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        tick(1);
        chk_pins("pins after reset", 60'h0, pins);
        chk_word("led after reset", 32'h0, {15'h0, common, segs});
        for (int s = 0; s < 4; s++) begin
            seed = xs(seed);
            mem[s][31:0] = seed;
            seed = xs(seed);
            mem[s][59:32] = seed[27:0];
            wb(1'b1, ADDR_MEM_BASE + 10'(8 * s), mem[s][31:0]);
            wb(1'b1, ADDR_MEM_BASE + 10'(8 * s + 4), seed);
        end
        wb(1'b0, ADDR_MEM_BASE + 10'h014, 32'h0);
        chk_word("mem high word", {4'h0, mem[2][59:32]}, rd);
        wb(1'b0, 10'h3F0, 32'h0);
        chk_word("unmapped read", 32'h0, rd);
        wb(1'b1, ADDR_START_CTRL, 32'h0000_00FC);
        wb(1'b0, ADDR_START_CTRL, 32'h0);
        chk_word("start reg read", 32'h0, rd);
        tick(3);
        chk_pins("unused start bits", 60'h0, pins);
        chk_word("unused start bits led", 32'h0, {15'h0, common, segs});
        wb(1'b1, ADDR_DIGIT_START, 32'h0);
        wb(1'b1, ADDR_DIGIT_COUNT, 32'h0);
        wb(1'b1, ADDR_SEG_MASK, 32'h0);
        wb(1'b1, ADDR_SEG_LEVEL, 32'h0);
        // Every slot width, with inversion on the odd codes.
        for (int code = 0; code < 4; code++) begin
            dur = 1 << (BASE + code);
            inv = code[0];
            wb(1'b1, ADDR_CONFIG_CTRL, {24'h0, inv, 2'(code), 5'h01});
            seed = xs(seed);
            wb(1'b1, ADDR_START_CTRL, {24'h0, seed[7:2], 2'b01});
            tick(1);
            chk_pins("first slot", exp_pins(mem[0], inv), pins);
            tick(dur - 2);
            chk_pins("slot end", exp_pins(mem[0], inv), pins);
            tick(1);
            chk_pins("second slot", exp_pins(mem[1], inv), pins);
            tick(dur);
            chk_pins("wrap", exp_pins(mem[0], inv), pins);
            wb(1'b1, ADDR_START_CTRL, {24'h0, seed[7:2], 2'b00});
            tick(0);
            chk_pins("slot held after stop", exp_pins(mem[0], inv), pins);
            for (int k = 0; k < dur + 4 && pins !== {60{inv}}; k++) begin
                tick(1);
            end
            chk_pins("tube off", {60{inv}}, pins);
        end
        // LED run with the tube inversion still set.
        wb(1'b1, ADDR_START_CTRL, 32'h0000_0002);
        tick(1);
        chk_word("led start", {15'h0, 1'b1, mem[0][15:0]}, {15'h0, common, segs});
        tick(SEG_LEN - 2);
        chk_word("led seg phase", {15'h0, 1'b1, mem[0][15:0]}, {15'h0, common, segs});
        tick(1);
        chk_word("led seg blank", {15'h0, 1'b1, 16'h0}, {15'h0, common, segs});
        tick(COM_LEN - SEG_LEN);
        chk_word("led low phase", {15'h0, 1'b0, mem[1][15:0]}, {15'h0, common, segs});
        tick(3);
        wb(1'b1, ADDR_START_CTRL, 32'h0);
        tick(0);
        chk_word("led stop", 32'h0, {15'h0, common, segs});
        chk_word("common rises", 32'h1, {16'h0, com_rises});
        // Digit pins 4 to 11 dimmed, segments dimmed in slot 0 only.
        // written while stopped.
        wb(1'b1, ADDR_CONFIG_CTRL, 32'h0000_0001);
        wb(1'b1, ADDR_DIGIT_START, 32'h0000_0404);
        wb(1'b1, ADDR_DIGIT_COUNT, 32'h0000_0008);
        wb(1'b1, ADDR_SEG_MASK, 32'h0000_0001);
        wb(1'b1, ADDR_SEG_LEVEL, 32'h0000_0002);
        wb(1'b1, ADDR_START_CTRL, 32'h0000_0001);
        tick(1);
        for (int j = 1; j < 17; j++) begin
            chk_pins("dimmed pins", exp_dim(mem[(j / 8) % 2], j), pins);
            tick(1);
        end
        wb(1'b1, ADDR_START_CTRL, 32'h0);
        tick(12);
        chk_pins("dimmed tube off", 60'h0, pins);
        results();
    end

    initial begin
        #(40 * 5000);
        errors++;
        results();
    end
endmodule
